// File: verilog/host_port_pkg.sv
package host_port_pkg;
   // host interface modes on {interface_mode_sel1, interface_mode_sel0}
   localparam logic [1:0] MODE_WIDE16 = 2'h0;
   localparam logic [1:0] MODE_BYTE8 = 2'h1;
   localparam logic [1:0] MODE_BYTE16 = 2'h2;
   localparam logic [1:0] MODE_SERIAL = 2'h3;
   // bus widths and buffer depth
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 8;
   // status word bit positions
   localparam int STATUS_READY_BIT = 0;
   localparam int STATUS_IRQ_BIT = 1;
   // byte lane enables
   localparam logic [15:0] OE_WIDE = 16'hFFFF;
   localparam logic [15:0] OE_BYTE = 16'h00FF;
   localparam logic [15:0] OE_NONE = 16'h0000;
   // typical busy-to-ready time, used as a watchdog figure only
   localparam real CLK_PERIOD_NS = 10.0;
   localparam real BUSY_TYPICAL_US = 12.5;
   localparam int BUSY_TYPICAL_CYCLES =
      int'($floor(BUSY_TYPICAL_US * 1000.0 / CLK_PERIOD_NS));
   localparam int BUSY_CNT_W = 11;
   // reset values of the synchronised pin groups: mode 16/16, select and
   // strobes idle high, instruction line low
   localparam logic [5:0] CTRL_IDLE = 6'h0E;
   typedef enum logic [1:0] {
      HP_IDLE, HP_WRITING, HP_READING, HP_STATUS
   } host_state_t;
endpackage : host_port_pkg

// File: verilog/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] s1, s2, s3, next_q;

   // a change is taken only once the second and third stages agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_comb begin
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
         end
      end
   endgenerate

   // s1 feeds s2 only: it may be metastable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
         q <= INIT;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q <= next_q;
      end
   end
endmodule : pin_sync
`default_nettype wire

// File: verilog/word_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr, next_rd;
   logic [AW:0] count, next_count;
   logic [WIDTH-1:0] next_out;
   logic push, pop;

   // head word is kept in a register so read data never comes from the array
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr = wr_ptr + AW'(push);
      next_rd = rd_ptr + AW'(pop);
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
      if (push && (count == '0 || (count == (AW+1)'(1) && pop)))
         next_out = in_data;
      else
         next_out = mem[next_rd];
   end

   always_ff @(posedge clk) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         out_data <= '0;
      end else begin
         wr_ptr <= next_wr;
         rd_ptr <= next_rd;
         count <= next_count;
         out_data <= next_out;
      end
   end

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
endmodule : word_fifo
`default_nettype wire

// File: verilog/motion_host_parallel_port.sv
`timescale 1ns/100ps
`default_nettype none
module motion_host_parallel_port #(
   parameter int FIFO_DEPTH = host_port_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic interface_mode_sel0,
   input wire logic interface_mode_sel1,
   input wire logic port_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic instr_data_select,
   input wire logic [15:0] host_data_in,
   output logic [15:0] host_data_out,
   output logic [15:0] host_data_oe,
   output logic port_ready_flag,
   input wire logic host_interrupt_flag,
   input wire logic core_address_bit0,
   input wire logic core_address_bit1,
   input wire logic core_address_bit15,
   input wire logic core_read_not_write,
   input wire logic core_bus_strobe_n,
   input wire logic peripheral_select_n,
   input wire logic [15:0] core_data_in,
   output logic [15:0] core_data_out,
   output logic core_data_oe,
   output logic core_word_is_instr,
   output logic transfer_irq_to_core,
   output logic core_clock_out,
   output logic busy_overrun
);
   localparam int W = host_port_pkg::WORD_W;
   localparam int B = host_port_pkg::BYTE_W;

   // core decodes this port by three address lines
   function automatic logic port_hit(input logic a0, input logic a1,
                                     input logic a15);
      return a0 && a1 && a15;
   endfunction

   logic [5:0] ctrl_s;
   logic [W-1:0] data_s;
   logic [1:0] mode;
   logic sel_n_s, rd_n_s, wr_n_s, cmd_s;
   logic byte_mode, serial_mode;

   // host pins come from another clock domain
   pin_sync #(.WIDTH(6), .INIT(host_port_pkg::CTRL_IDLE)) u_ctrl_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({interface_mode_sel1, interface_mode_sel0, port_select_n,
          read_strobe_n, write_strobe_n, instr_data_select}),
      .q(ctrl_s)
   );
   pin_sync #(.WIDTH(W), .INIT('0)) u_data_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(host_data_in),
      .q(data_s)
   );

   // mode decode
   always_comb begin
      {mode, sel_n_s, rd_n_s, wr_n_s, cmd_s} = ctrl_s;
      byte_mode = (mode == host_port_pkg::MODE_BYTE8) ||
                  (mode == host_port_pkg::MODE_BYTE16);
      serial_mode = (mode == host_port_pkg::MODE_SERIAL);
   end

   host_port_pkg::host_state_t state, next_state;
   logic byte_phase, next_byte_phase;
   logic [B-1:0] low_byte, next_low_byte;
   logic [W-1:0] wlatch, next_wlatch;
   logic [W-1:0] read_word, next_read_word;
   logic [W-1:0] next_host_out, next_host_oe;
   logic busy, next_busy, next_ready, next_irq;
   logic wcmd, next_wcmd;
   logic word_done, core_done, fifo_push, fifo_in_ready;
   logic [W:0] fifo_in, fifo_out;
   logic fifo_valid, fifo_pop;
   logic strobe_q, next_strobe_q, core_start, core_hit;
   logic [W-1:0] next_core_out;
   logic next_core_oe, next_core_instr, next_clk_div, next_overrun;
   logic [host_port_pkg::BUSY_CNT_W-1:0] busy_cnt, next_busy_cnt;

   // host side sequencing: strobes only count with select low and not serial
   always_comb begin
      next_state = state;
      next_byte_phase = byte_phase;
      next_low_byte = low_byte;
      next_wlatch = wlatch;
      next_wcmd = wcmd;
      next_host_out = host_data_out;
      next_host_oe = host_data_oe;
      word_done = 1'b0;
      fifo_push = 1'b0;
      fifo_in = {wcmd, wlatch};
      unique case (state)
         host_port_pkg::HP_IDLE: begin
            if (!sel_n_s && !serial_mode) begin
               if (!rd_n_s && cmd_s) begin
                  next_state = host_port_pkg::HP_STATUS;
                  next_host_out = '0;
                  next_host_out[host_port_pkg::STATUS_READY_BIT] =
                     port_ready_flag;
                  next_host_out[host_port_pkg::STATUS_IRQ_BIT] =
                     host_interrupt_flag;
                  next_host_oe = byte_mode ? host_port_pkg::OE_BYTE
                                           : host_port_pkg::OE_WIDE;
               end else if (!rd_n_s && port_ready_flag) begin
                  next_state = host_port_pkg::HP_READING;
                  if (!byte_mode)
                     next_host_out = read_word;
                  else if (byte_phase)
                     next_host_out = {{B{1'b0}}, read_word[W-1:B]};
                  else
                     next_host_out = {{B{1'b0}}, read_word[B-1:0]};
                  next_host_oe = byte_mode ? host_port_pkg::OE_BYTE
                                           : host_port_pkg::OE_WIDE;
               end else if (!wr_n_s && port_ready_flag) begin
                  next_state = host_port_pkg::HP_WRITING;
                  next_wlatch = data_s;
                  next_wcmd = cmd_s;
               end
            end
         end
         host_port_pkg::HP_WRITING: begin
            if (!wr_n_s && !sel_n_s) begin
               // keep sampling: write data needs no hold after the strobe
               next_wlatch = data_s;
               next_wcmd = cmd_s;
            end else begin
               next_state = host_port_pkg::HP_IDLE;
               if (!byte_mode) begin
                  word_done = 1'b1;
                  fifo_push = 1'b1;
               end else if (!byte_phase) begin
                  next_low_byte = wlatch[B-1:0];
                  next_byte_phase = 1'b1;
               end else begin
                  fifo_in = {wcmd, wlatch[B-1:0], low_byte};
                  word_done = 1'b1;
                  fifo_push = 1'b1;
                  next_byte_phase = 1'b0;
               end
            end
         end
         host_port_pkg::HP_READING: begin
            if (rd_n_s || sel_n_s) begin
               next_state = host_port_pkg::HP_IDLE;
               next_host_oe = host_port_pkg::OE_NONE;
               if (!byte_mode || byte_phase) begin
                  word_done = 1'b1;
                  next_byte_phase = 1'b0;
               end else begin
                  next_byte_phase = 1'b1;
               end
            end
         end
         host_port_pkg::HP_STATUS: begin
            // status leaves byte phase and busy untouched
            if (rd_n_s || sel_n_s) begin
               next_state = host_port_pkg::HP_IDLE;
               next_host_oe = host_port_pkg::OE_NONE;
            end
         end
      endcase
   end

   // core side: a peripheral access to this port, qualified by strobe
   always_comb begin
      core_hit = port_hit(core_address_bit0, core_address_bit1,
                          core_address_bit15);
      next_strobe_q = !core_bus_strobe_n && !peripheral_select_n &&
                      core_hit;
      core_start = next_strobe_q && !strobe_q;
      fifo_pop = core_start && core_read_not_write && fifo_valid;
      core_done = core_start && !core_read_not_write;
      next_read_word = core_done ? core_data_in : read_word;
      next_core_out = fifo_pop ? fifo_out[W-1:0] : core_data_out;
      next_core_instr = fifo_pop ? fifo_out[W] : core_word_is_instr;
      next_core_oe = next_strobe_q && core_read_not_write;
   end

   // busy flag: a word finishing in the same cycle as core_done wins
   always_comb begin
      next_busy = busy;
      if (core_done)
         next_busy = 1'b0;
      if (word_done)
         next_busy = 1'b1;
      next_ready = !next_busy && fifo_in_ready && !serial_mode;
      next_irq = word_done;
      next_clk_div = !core_clock_out;
      next_busy_cnt = busy ? busy_cnt : '0;
      next_overrun = busy_overrun && busy;
      if (busy && busy_cnt !=
          host_port_pkg::BUSY_CNT_W'(host_port_pkg::BUSY_TYPICAL_CYCLES))
         next_busy_cnt = busy_cnt + 1'b1;
      else if (busy)
         next_overrun = 1'b1;
   end

   word_fifo #(.WIDTH(W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= host_port_pkg::HP_IDLE;
         byte_phase <= 1'b0;
         low_byte <= '0;
         wlatch <= '0;
         wcmd <= 1'b0;
         read_word <= '0;
         host_data_out <= '0;
         host_data_oe <= host_port_pkg::OE_NONE;
         busy <= 1'b0;
         port_ready_flag <= 1'b0;
         transfer_irq_to_core <= 1'b0;
         strobe_q <= 1'b0;
         core_data_out <= '0;
         core_data_oe <= 1'b0;
         core_word_is_instr <= 1'b0;
         core_clock_out <= 1'b0;
         busy_cnt <= '0;
         busy_overrun <= 1'b0;
      end else begin
         state <= next_state;
         byte_phase <= next_byte_phase;
         low_byte <= next_low_byte;
         wlatch <= next_wlatch;
         wcmd <= next_wcmd;
         read_word <= next_read_word;
         host_data_out <= next_host_out;
         host_data_oe <= next_host_oe;
         busy <= next_busy;
         port_ready_flag <= next_ready;
         transfer_irq_to_core <= next_irq;
         strobe_q <= next_strobe_q;
         core_data_out <= next_core_out;
         core_data_oe <= next_core_oe;
         core_word_is_instr <= next_core_instr;
         core_clock_out <= next_clk_div;
         busy_cnt <= next_busy_cnt;
         busy_overrun <= next_overrun;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_busy_after_word: assert property (
      word_done |=> !port_ready_flag ##1 !port_ready_flag)
      else $error("ready not low after completed word");
   a_ready_on_done: assert property (
      core_done && !word_done && fifo_in_ready && !serial_mode
      |=> port_ready_flag)
      else $error("ready not restored after core done");
   a_irq_one_pulse: assert property (
      word_done |=> transfer_irq_to_core ##1 !transfer_irq_to_core)
      else $error("core interrupt not a single pulse");
   a_select_gates_host: assert property (
      state == host_port_pkg::HP_IDLE && sel_n_s
      |=> state == host_port_pkg::HP_IDLE)
      else $error("strobe acted without port select");
   a_read_drives_bus: assert property (
      $rose(state == host_port_pkg::HP_READING) |-> host_data_oe != '0)
      else $error("read strobe did not drive host bus");
   a_push_from_write: assert property (
      fifo_push |-> state == host_port_pkg::HP_WRITING && $past(!wr_n_s))
      else $error("word taken outside a write strobe");
   a_status_is_cmd: assert property (
      $rose(state == host_port_pkg::HP_STATUS) |-> $past(cmd_s))
      else $error("status read without instruction select");
   a_status_no_change: assert property (
      state == host_port_pkg::HP_STATUS |-> !word_done && !fifo_push)
      else $error("status read changed port state");
   a_byte_second_push: assert property (
      fifo_push && byte_mode |-> byte_phase)
      else $error("byte mode pushed on first byte");
   a_core_read_dir: assert property (
      core_data_oe |-> $past(core_read_not_write && core_hit))
      else $error("core bus driven outside a port read");
   a_core_clk_half: assert property (
      core_clock_out |=> !core_clock_out ##1 core_clock_out)
      else $error("core clock not master divided by two");

   c_word_write: cover property (fifo_push && !byte_mode);
   c_byte_write: cover property (fifo_push && byte_mode);
   c_host_read: cover property (
      word_done && state == host_port_pkg::HP_READING);
   c_busy_cycle: cover property (!port_ready_flag ##[1:50] port_ready_flag);
endmodule : motion_host_parallel_port
`default_nettype wire

// File: testbench/host_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// host processor on the parallel port; pins change just after a clock edge
module host_cpu_model (
   input wire logic clk,
   output logic port_select_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic instr_data_select,
   output logic [15:0] host_data_in,
   input wire logic [15:0] host_data_out,
   input wire logic [15:0] host_data_oe,
   input wire logic port_ready_flag
);
   logic [15:0] drv = 16'h0000;
   logic drv_en = 1'b0;

   initial begin
      port_select_n = 1'b1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      instr_data_select = 1'b0;
   end

   // wire level: device lanes win; a released host lane shows the
   // inverse of its last value, so stale data never looks valid
   assign host_data_in = (host_data_oe & host_data_out) |
      (~host_data_oe & (drv_en ? drv : ~drv));

   // one strobe cycle; strobes stay low 9 clocks so the filter sees them
   task automatic xfer(input logic rd, input logic cmd, input logic sel,
      input logic wait_rdy, input logic [15:0] wdata,
      output logic [15:0] rdata, output logic [15:0] oe, output logic ok);
      int n;
      ok = 1'b1;
      n = 0;
      // with wait_rdy set the host waits up to 3000 clocks for ready, then starts anyway
      while (wait_rdy && port_ready_flag !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n == 3000) ok = 1'b0;
      @(posedge clk);
      port_select_n <= ~sel;
      instr_data_select <= cmd;
      drv <= wdata;
      drv_en <= ~rd;
      @(posedge clk);
      if (rd) read_strobe_n <= 1'b0;
      else write_strobe_n <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      rdata = host_data_out;
      oe = host_data_oe;
      @(posedge clk);
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      @(posedge clk);
      port_select_n <= 1'b1;
      drv_en <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : xfer
endmodule : host_cpu_model
`default_nettype wire

// File: testbench/motion_host_parallel_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
module motion_host_parallel_port_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] mode = 2'h0;
   logic hif = 1'b0;
   logic [2:0] addr = 3'h0;
   logic rnw = 1'b0;
   logic cstb_n = 1'b1;
   logic psel_n = 1'b1;
   logic [15:0] cdin = 16'h0000;
   logic sel_n, rd_n, wr_n, cmd, rdy, cdoe, is_instr, irq, cclk, ovr, b, ok;
   logic coe;
   logic [15:0] hdin, hdout, hdoe, cdout, rd, oe;
   int n_errors = 0;
   int checked = 0;
   int irq_n = 0;

   always #5 clk = ~clk;
   // count core interrupt pulses, one per completed word
   always @(posedge clk) if (irq === 1'b1) irq_n++;

   motion_host_parallel_port motion_host_parallel_port_i (
      .clk(clk), .rst_n(rst_n),
      .interface_mode_sel0(mode[0]), .interface_mode_sel1(mode[1]),
      .port_select_n(sel_n), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .instr_data_select(cmd),
      .host_data_in(hdin), .host_data_out(hdout), .host_data_oe(hdoe),
      .port_ready_flag(rdy), .host_interrupt_flag(hif),
      .core_address_bit0(addr[0]), .core_address_bit1(addr[1]),
      .core_address_bit15(addr[2]), .core_read_not_write(rnw),
      .core_bus_strobe_n(cstb_n), .peripheral_select_n(psel_n),
      .core_data_in(cdin), .core_data_out(cdout), .core_data_oe(cdoe),
      .core_word_is_instr(is_instr), .transfer_irq_to_core(irq),
      .core_clock_out(cclk), .busy_overrun(ovr)
   );

   host_cpu_model host_cpu_model_i (
      .clk(clk), .port_select_n(sel_n), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .instr_data_select(cmd),
      .host_data_in(hdin), .host_data_out(hdout), .host_data_oe(hdoe),
      .port_ready_flag(rdy)
   );

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // host access: read, instr line, selected, wait for ready, write data
   task automatic host(input logic r, input logic c, input logic s,
      input logic w, input logic [15:0] d);
      host_cpu_model_i.xfer(r, c, s, w, d, rd, oe, ok);
      if (ok !== 1'b1) begin
         n_errors++;
         wrap_up();
      end
   endtask : host

   // one core bus access; a is {bit15, bit1, bit0}, p the peripheral select
   task automatic core(input logic r, input logic [2:0] a, input logic p,
      input logic [15:0] d);
      @(posedge clk);
      rnw <= r;
      addr <= a;
      psel_n <= p;
      cdin <= d;
      cstb_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      coe = cdoe; // sampled while the strobe still stands
      @(posedge clk);
      cstb_n <= 1'b1;
      psel_n <= 1'b1;
      addr <= 3'h0;
      cdin <= ~d;
      repeat (2) @(posedge clk);
      #1;
   endtask : core

   // hang guard, far beyond the longest expected run
   initial begin
      #500000;
      n_errors++;
      wrap_up();
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk(16'(rdy), 16'h0001);
      chk(hdoe, host_port_pkg::OE_NONE);
      for (int i = 0; i < 4; i++) begin
         b = cclk;
         @(posedge clk);
         #1;
         chk(16'(cclk), 16'(!b));
      end
      host(1'b0, 1'b1, 1'b1, 1'b1, 16'hA5C3);
      chk(16'(rdy), 16'h0000);
      chk(16'(irq_n), 16'h0001);
      // while busy, a data write and unselected strobes are both ignored
      host(1'b0, 1'b0, 1'b1, 1'b0, 16'h0BAD);
      host(1'b0, 1'b0, 1'b0, 1'b0, 16'h0BAD);
      chk(16'(irq_n), 16'h0001);
      @(posedge clk);
      hif <= 1'b1;
      host(1'b1, 1'b1, 1'b1, 1'b0, 16'h0000);
      chk({14'h0, rd[1:0]}, 16'h0002);
      chk(16'(irq_n), 16'h0001);
      core(1'b1, 3'h7, 1'b0, 16'h0000);
      chk(cdout, 16'hA5C3);
      chk(16'(coe), 16'h0001);
      chk(16'(is_instr), 16'h0001);
      core(1'b0, 3'h3, 1'b0, 16'h1234);
      core(1'b0, 3'h7, 1'b1, 16'h1234);
      chk(16'(rdy), 16'h0000);
      repeat (1300) @(posedge clk);
      #1;
      chk(16'(ovr), 16'h0001);
      core(1'b0, 3'h7, 1'b0, 16'h1234);
      chk(16'(coe), 16'h0000);
      chk(16'(rdy), 16'h0001);
      chk(16'(ovr), 16'h0000);
      host(1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
      chk(rd, 16'h1234);
      chk(oe, host_port_pkg::OE_WIDE);
      chk(16'(rdy), 16'h0000);
      chk(16'(irq_n), 16'h0002);
      core(1'b0, 3'h7, 1'b0, 16'hBEEF);
      // both byte-wide modes: low byte first, busy only after the second
      for (int m = 1; m < 3; m++) begin
         @(posedge clk);
         mode <= 2'(m);
         repeat (6) @(posedge clk);
         host(1'b0, 1'b0, 1'b1, 1'b1, 16'h0034);
         chk(16'(rdy), 16'h0001);
         host(1'b0, 1'b1, 1'b1, 1'b1, 16'h0012);
         chk(16'(rdy), 16'h0000);
         core(1'b1, 3'h7, 1'b0, 16'h0000);
         chk(cdout, 16'h1234);
         chk(16'(is_instr), 16'h0001);
         core(1'b0, 3'h7, 1'b0, 16'hBEEF);
         host(1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
         chk(rd & oe, 16'h00EF);
         chk(oe, host_port_pkg::OE_BYTE);
         host(1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
         chk(rd & oe, 16'h00BE);
         chk(16'(rdy), 16'h0000);
         core(1'b0, 3'h7, 1'b0, 16'hBEEF);
      end
      chk(16'(irq_n), 16'h0006);
      @(posedge clk);
      mode <= host_port_pkg::MODE_WIDE16;
      repeat (6) @(posedge clk);
      // fill the buffer with no pops: the eighth core write cannot free it
      for (int i = 0; i < 8; i++) begin
         host(1'b0, 1'b0, 1'b1, 1'b1, 16'(16'hC000 + i));
         core(1'b0, 3'h7, 1'b0, 16'hBEEF);
      end
      chk(16'(rdy), 16'h0000);
      for (int i = 0; i < 8; i++) begin
         core(1'b1, 3'h7, 1'b0, 16'h0000);
         chk(cdout, 16'(16'hC000 + i));
         chk(16'(is_instr), 16'h0000);
      end
      core(1'b0, 3'h7, 1'b0, 16'hBEEF);
      chk(16'(rdy), 16'h0001);
      @(posedge clk);
      mode <= host_port_pkg::MODE_SERIAL;
      repeat (6) @(posedge clk);
      #1;
      chk(16'(rdy), 16'h0000);
      host(1'b0, 1'b0, 1'b1, 1'b0, 16'h0BAD);
      chk(16'(irq_n), 16'h000E);
      wrap_up();
   end
endmodule : motion_host_parallel_port_bench
`default_nettype wire
